//--- pfsw_flash_ctrl.v
// program flash self-write controller: registers, unlock, sequencing
// assumes: AHB-Lite single word transfers, one slave; guard and code
// protect come from configuration pins; porRstn only at power-up
//
// Behaviour
// R1 - data pair forms one 14-bit word for reads and writes
// R2 - address pair forms one 15-bit word address
// R3 - address pair reaches at most 32K words
// R4 - software puts high address part high, low part low
// R5 - read and write triggers ignore software writes of zero
// R6 - hardware clears each trigger when its operation completes
// R7 - writes need the enable bit, which is clear at power-up
// R8 - reset during a write sets the abort flag, kept past reset
// R9 - unlock-key register is write-only and reads zero
// R10 - latch or memory writes need the unlock key first
// R11 - program and erase duration comes from an internal timer
// R12 - guard field selects a region refusing self erase and write
// R13 - code protection leaves self erase and write working
// R14 - erase acts on whole 32-word rows; 32 write latches
// R15 - latches are filled through the data pair, not addressed
// R16 - unprogrammed words accept writes without prior erase
// R17 - key is 55h then AAh before the write trigger
// R18 - read uses the second cycle after trigger, data next cycle
// R19 - erase or row program stalls execution about 2 ms
// R20 - completed program reloads every latch with 3FFF
// R21 - write trigger without unlock or enable starts nothing
`timescale 1ns/1ps
`default_nettype none
`include "pfsw_consts.vh"

module pfsw_flash_ctrl #(
  parameter ADDR_W    = `PFSW_ADDR_W,
  parameter WORD_W    = `PFSW_WORD_W,
  parameter ROW_BITS  = `PFSW_ROW_BITS,
  parameter OP_CYCLES = `PFSW_PROG_CYCLES
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire        porRstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire [1:0]  selfProgramGuard,
  input  wire        codeProtect,
  output reg         cpuStall
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_READ = 4'h2;
  localparam [3:0] ST_LOAD = 4'h4;
  localparam [3:0] ST_LONG = 4'h8;
  localparam       ROWS_W  = ADDR_W - ROW_BITS;
  localparam       LATCHES = 1 << ROW_BITS;

  // register file
  reg [7:0]                   addrLow_reg;
  reg [`PFSW_ADDR_HIGH_W-1:0] addrHigh_reg;
  reg [7:0]                   dataLow_reg;
  reg [`PFSW_DATA_HIGH_W-1:0] dataHigh_reg;
  reg                         readTrig_reg;
  reg                         writeTrig_reg;
  reg                         programEnable_reg;
  reg                         programAbortFlag_reg;
  reg                         eraseSel_reg;
  reg                         latchSel_reg;
  reg                         keyFirst_reg;
  reg                         unlocked_reg;
  reg [3:0]                   state_reg;
  reg [1:0]                   phase_reg;
  reg                         arrStart_reg;
  reg                         arrRdEn_reg;
  // bus data phase
  reg                         wrPend_reg;
  reg [7:0]                   wrOff_reg;
  // configuration pin synchronisers
  reg [1:0]                   guardS1_reg;
  reg [1:0]                   guardS2_reg;
  reg [1:0]                   guardS3_reg;
  reg [1:0]                   guard_reg;
  reg                         cpS1_reg;
  reg                         cpS2_reg;
  reg                         cpS3_reg;
  reg                         cp_reg;
  // write latches
  reg [WORD_W-1:0]            latch [0:LATCHES-1];

  wire [ADDR_W-1:0]   wordAddr;
  wire [WORD_W-1:0]   dataWord;
  wire [ROW_BITS-1:0] latchIdx;
  wire [WORD_W-1:0]   arrRdData;
  wire                arrDone;
  wire [7:0]          wrByte;
  wire                addrPhase;
  wire                ctlWrite;
  wire                wantRead;
  wire                wantWrite;
  wire                opAllowed;
  integer             i;

  // high and low address parts join into one word address [R2] [R3] [R4]
  assign wordAddr  = {addrHigh_reg, addrLow_reg};
  // data pair joins into one 14-bit word [R1]
  assign dataWord  = {dataHigh_reg, dataLow_reg};
  assign wrByte    = hwdata[7:0];
  assign addrPhase = hready && hsel && htrans[1];
  assign ctlWrite  = wrPend_reg && wrOff_reg == `PFSW_OFF_CONTROL;
  // a written zero never clears a trigger [R5]
  assign wantRead  = ctlWrite && wrByte[`PFSW_CTL_READ];
  assign wantWrite = ctlWrite && wrByte[`PFSW_CTL_WRITE];

  // true when the word address lies in the guarded region
  function guarded;
    input [1:0]        guardSel;
    input [ADDR_W-1:0] addr;
    begin
      case (guardSel)
        `PFSW_GUARD_OFF:     guarded = 1'b0;
        `PFSW_GUARD_QUARTER: guarded = addr[ADDR_W-1:ADDR_W-2] == 2'h0;
        `PFSW_GUARD_HALF:    guarded = !addr[ADDR_W-1];
        default:             guarded = 1'b1;
      endcase
    end
  endfunction

  // register read mux; the key register always reads zero [R9]
  function [7:0] readMux;
    input [7:0] off;
    begin
      case (off)
        `PFSW_OFF_ADDR_LOW:  readMux = addrLow_reg;
        `PFSW_OFF_ADDR_HIGH: readMux = {1'b0, addrHigh_reg};
        `PFSW_OFF_DATA_LOW:  readMux = dataLow_reg;
        `PFSW_OFF_DATA_HIGH: readMux = {2'h0, dataHigh_reg};
        `PFSW_OFF_CONTROL:   readMux = {1'b0, cp_reg, latchSel_reg,
                                        eraseSel_reg, programAbortFlag_reg,
                                        programEnable_reg, writeTrig_reg,
                                        readTrig_reg};
        default:             readMux = 8'h00;
      endcase
    end
  endfunction

  // code protection only reaches the status bit, never the gating [R13]
  // latch loads skip the region check; only erase and program are barred
  assign opAllowed = unlocked_reg && programEnable_reg &&       // [R21]
                     (latchSel_reg && !eraseSel_reg ||
                      !guarded(guard_reg, wordAddr));            // [R12]

  // three-stage pin synchronisers; a change counts once stages 2 and 3
  // agree, which also filters a single-cycle glitch
  always @(posedge clock) begin
    if (!rstn) begin
      guardS1_reg <= 2'h0;
      guardS2_reg <= 2'h0;
      guardS3_reg <= 2'h0;
      guard_reg   <= 2'h0;
      cpS1_reg    <= 1'b0;
      cpS2_reg    <= 1'b0;
      cpS3_reg    <= 1'b0;
      cp_reg      <= 1'b0;
    end else begin
      guardS1_reg <= selfProgramGuard;
      guardS2_reg <= guardS1_reg;
      guardS3_reg <= guardS2_reg;
      cpS1_reg    <= codeProtect;
      cpS2_reg    <= cpS1_reg;
      cpS3_reg    <= cpS2_reg;
      if (guardS2_reg == guardS3_reg)
        guard_reg <= guardS3_reg;
      if (cpS2_reg == cpS3_reg)
        cp_reg <= cpS3_reg;
    end
  end

  // bus slave: zero wait states, always OKAY, read data registered
  always @(posedge clock) begin
    if (!rstn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0;
      wrPend_reg <= 1'b0;
      wrOff_reg  <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wrPend_reg <= addrPhase && hwrite;
        wrOff_reg  <= haddr[7:0];
      end
      if (addrPhase && !hwrite)
        hrdata <= {24'h0, readMux(haddr[7:0])};
    end
  end

  // abort flag survives an ordinary reset; power-up or a control write with bit 3 clear clears it
  always @(posedge clock) begin
    if (!porRstn)
      programAbortFlag_reg <= 1'b0;
    else if (!rstn && writeTrig_reg)
      programAbortFlag_reg <= 1'b1;                              // [R8]
    else if (rstn && ctlWrite)
      programAbortFlag_reg <= wrByte[`PFSW_CTL_ABORT];
  end

  // enable bit clears on power-up and on every ordinary reset as well
  always @(posedge clock) begin
    if (!porRstn)
      programEnable_reg <= 1'b0;                                 // [R7]
    else if (!rstn)
      programEnable_reg <= 1'b0;
    else if (ctlWrite)
      programEnable_reg <= wrByte[`PFSW_CTL_ENABLE];
  end

  // unlock sequence: 55h then AAh, any other bus write breaks it
  always @(posedge clock) begin
    if (!rstn) begin
      keyFirst_reg <= 1'b0;
      unlocked_reg <= 1'b0;
    end else if (wrPend_reg) begin
      if (wrOff_reg == `PFSW_OFF_KEY) begin
        keyFirst_reg <= wrByte == `PFSW_KEY_FIRST;               // [R17]
        unlocked_reg <= keyFirst_reg &&
                        wrByte == `PFSW_KEY_SECOND;              // [R10]
      end else begin
        // the trigger write consumes the key, allowed or not
        keyFirst_reg <= 1'b0;
        unlocked_reg <= 1'b0;
      end
    end
  end

  // address and data pair, mode bits, triggers and the sequencer
  always @(posedge clock) begin
    arrStart_reg <= 1'b0;
    arrRdEn_reg  <= 1'b0;
    if (!rstn) begin
      addrLow_reg   <= 8'h00;
      addrHigh_reg  <= {`PFSW_ADDR_HIGH_W{1'b0}};
      dataLow_reg   <= 8'h00;
      dataHigh_reg  <= {`PFSW_DATA_HIGH_W{1'b0}};
      readTrig_reg  <= 1'b0;
      writeTrig_reg <= 1'b0;
      eraseSel_reg  <= 1'b0;
      latchSel_reg  <= 1'b0;
      state_reg     <= ST_IDLE;
      phase_reg     <= 2'h0;
      cpuStall      <= 1'b0;
      arrStart_reg  <= 1'b0;
      arrRdEn_reg   <= 1'b0;
    end else begin
      if (wrPend_reg) begin
        case (wrOff_reg)
          `PFSW_OFF_ADDR_LOW:  addrLow_reg  <= wrByte;
          `PFSW_OFF_ADDR_HIGH: addrHigh_reg <=
                                 wrByte[`PFSW_ADDR_HIGH_W-1:0];
          `PFSW_OFF_DATA_LOW:  dataLow_reg  <= wrByte;
          `PFSW_OFF_DATA_HIGH: dataHigh_reg <=
                                 wrByte[`PFSW_DATA_HIGH_W-1:0];
          `PFSW_OFF_CONTROL: begin
            // mode bits freeze while an operation runs
            if (state_reg == ST_IDLE) begin
              eraseSel_reg <= wrByte[`PFSW_CTL_ERASE];
              latchSel_reg <= wrByte[`PFSW_CTL_LATCH];
            end
          end
          default: ;
        endcase
      end
      case (state_reg)
        ST_IDLE: begin
          phase_reg <= 2'h0;
          if (wantRead) begin
            readTrig_reg <= 1'b1;                                // [R5]
            state_reg    <= ST_READ;
          end else if (wantWrite && opAllowed) begin
            writeTrig_reg <= 1'b1;                               // [R7]
            if (latchSel_reg && !eraseSel_reg) begin
              state_reg <= ST_LOAD;                              // [R15]
            end else begin
              state_reg    <= ST_LONG;
              arrStart_reg <= 1'b1;
              cpuStall     <= 1'b1;                              // [R19]
            end
          end
        end
        ST_READ: begin
          phase_reg <= phase_reg + 2'h1;
          // array is read in the second cycle after the trigger
          if (phase_reg == `PFSW_READ_ISSUE - 2'h1)
            arrRdEn_reg <= 1'b1;                                 // [R18]
          // the array word lands one edge after the read enable, so
          // capture it only once its own register has been loaded
          if (phase_reg == `PFSW_READ_DONE) begin
            dataLow_reg  <= arrRdData[7:0];                      // [R1]
            dataHigh_reg <= arrRdData[WORD_W-1:8];
            readTrig_reg <= 1'b0;                                // [R6]
            state_reg    <= ST_IDLE;
          end
        end
        ST_LOAD: begin
          phase_reg <= phase_reg + 2'h1;
          if (phase_reg == `PFSW_LOAD_DONE) begin
            writeTrig_reg <= 1'b0;                               // [R6]
            state_reg     <= ST_IDLE;
          end
        end
        ST_LONG: begin
          if (arrDone) begin
            writeTrig_reg <= 1'b0;                               // [R6]
            cpuStall      <= 1'b0;                               // [R19]
            state_reg     <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // write latches: the low address bits pick the one loaded, software
  // never addresses them directly; a finished program refills them
  always @(posedge clock) begin
    if (!rstn) begin
      for (i = 0; i < LATCHES; i = i + 1)
        latch[i] <= `PFSW_ERASED;
    end else if (state_reg == ST_LOAD && phase_reg == 2'h0) begin
      latch[wordAddr[ROW_BITS-1:0]] <= dataWord;                 // [R15]
    end else if (state_reg == ST_LONG && arrDone && !eraseSel_reg) begin
      for (i = 0; i < LATCHES; i = i + 1)
        latch[i] <= `PFSW_ERASED;                                // [R20]
    end
  end

  // array and its timer; the row is the upper address bits [R14]
  pfsw_flash_array #(
    .ADDR_W   (ADDR_W),
    .WORD_W   (WORD_W),
    .ROW_BITS (ROW_BITS),
    .OP_CYCLES(OP_CYCLES)
  ) u_array (
    .clock    (clock),
    .rstn     (rstn),
    .start    (arrStart_reg),
    .erase    (eraseSel_reg),
    .rowAddr  (wordAddr[ADDR_W-1:ROW_BITS]),
    .latchIdx (latchIdx),
    .latchWord(latch[latchIdx]),
    .rdEn     (arrRdEn_reg),
    .rdAddr   (wordAddr),
    .rdData   (arrRdData),
    .done     (arrDone)                                          // [R11]
  );

endmodule // pfsw_flash_ctrl
`default_nettype wire

//--- pfsw_consts.vh
// constants for the program flash self-write controller
// assumes: included by bare name from every design file of the block
`ifndef PFSW_CONSTS_VH
`define PFSW_CONSTS_VH

// register byte offsets on the bus, one aligned word each
`define PFSW_OFF_ADDR_LOW  8'h00
`define PFSW_OFF_ADDR_HIGH 8'h04
`define PFSW_OFF_DATA_LOW  8'h08
`define PFSW_OFF_DATA_HIGH 8'h0C
`define PFSW_OFF_CONTROL   8'h10
`define PFSW_OFF_KEY       8'h14

// control register bit positions
`define PFSW_CTL_READ    0
`define PFSW_CTL_WRITE   1
`define PFSW_CTL_ENABLE  2
`define PFSW_CTL_ABORT   3
`define PFSW_CTL_ERASE   4
`define PFSW_CTL_LATCH   5
`define PFSW_CTL_CPROT   6

// unlock key bytes, in the order they must arrive
`define PFSW_KEY_FIRST  8'h55
`define PFSW_KEY_SECOND 8'hAA

// word and address geometry
`define PFSW_WORD_W      14
`define PFSW_ADDR_W      15
`define PFSW_ROW_BITS    5
`define PFSW_ROW_WORDS   32
`define PFSW_ERASED      14'h3FFF
`define PFSW_DATA_HIGH_W 6
`define PFSW_ADDR_HIGH_W 7

// read and latch-load timing in cycles after the trigger write
`define PFSW_READ_ISSUE  2'h1
`define PFSW_READ_DONE   2'h2
`define PFSW_LOAD_DONE   2'h1

// erase / row program time and clock period
`define PFSW_PROG_TIME_NS 2000000
`define PFSW_CLK_NS       10
`define PFSW_PROG_CYCLES  (`PFSW_PROG_TIME_NS / `PFSW_CLK_NS)

// bus encodings
`define PFSW_HTRANS_NONSEQ 2'h2
`define PFSW_HTRANS_SEQ    2'h3

// write-protect field encodings
`define PFSW_GUARD_OFF     2'h3
`define PFSW_GUARD_QUARTER 2'h2
`define PFSW_GUARD_HALF    2'h1

`endif

//--- pfsw_flash_array.v
// program memory array with the internal erase / row program timer
// assumes: start is a one-cycle pulse while idle; latchWord answers
// latchIdx in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "pfsw_consts.vh"

module pfsw_flash_array #(
  parameter ADDR_W    = `PFSW_ADDR_W,
  parameter WORD_W    = `PFSW_WORD_W,
  parameter ROW_BITS  = `PFSW_ROW_BITS,
  parameter OP_CYCLES = `PFSW_PROG_CYCLES
) (
  input  wire                     clock,
  input  wire                     rstn,
  input  wire                     start,
  input  wire                     erase,
  input  wire [ADDR_W-ROW_BITS-1:0] rowAddr,
  output wire [ROW_BITS-1:0]      latchIdx,
  input  wire [WORD_W-1:0]        latchWord,
  input  wire                     rdEn,
  input  wire [ADDR_W-1:0]        rdAddr,
  output reg  [WORD_W-1:0]        rdData,
  output reg                      done
);

  localparam [31:0] ROW_WORDS = 32'd1 << ROW_BITS;

  reg [WORD_W-1:0]          mem [0:(1<<ADDR_W)-1];
  reg                       busy_reg;
  reg                       erase_reg;
  reg [ADDR_W-ROW_BITS-1:0] row_reg;
  reg [31:0]                cnt_reg;

  assign latchIdx = cnt_reg[ROW_BITS-1:0];

  // timer and row walk; duration is fixed here, not by software [R11]
  always @(posedge clock) begin
    done <= 1'b0;
    if (!rstn) begin
      busy_reg  <= 1'b0;
      erase_reg <= 1'b0;
      row_reg   <= {(ADDR_W-ROW_BITS){1'b0}};
      cnt_reg   <= 32'h0;
      done      <= 1'b0;
    end else if (start && !busy_reg) begin
      busy_reg  <= 1'b1;
      erase_reg <= erase;
      row_reg   <= rowAddr;
      cnt_reg   <= 32'h0;
    end else if (busy_reg) begin
      if (cnt_reg == OP_CYCLES - 1) begin
        busy_reg <= 1'b0;
        done     <= 1'b1;
      end
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  // whole-row erase, program only pulls bits low [R14] [R16]
  always @(posedge clock) begin
    if (busy_reg && cnt_reg < ROW_WORDS) begin
      if (erase_reg)
        mem[{row_reg, latchIdx}] <= `PFSW_ERASED;
      else
        mem[{row_reg, latchIdx}] <= mem[{row_reg, latchIdx}] & latchWord;
    end
  end

  // registered read port
  always @(posedge clock) begin
    if (rdEn)
      rdData <= mem[rdAddr];
  end

endmodule // pfsw_flash_array
`default_nettype wire

//--- pfsw_flash_ctrl_assertions.sv
// checker for the flash self-write controller, bound to its top module
// assumes: single bus slave, hready tied to hreadyout, one clock domain
`timescale 1ns/1ps
`default_nettype none

module pfsw_flash_ctrl_assertions #(
  parameter OP_CYCLES = 200000
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [1:0]  selfProgramGuard,
  input wire logic        cpuStall
);
  logic        ctlWr;
  logic [3:0]  sinceTrig;
  logic [31:0] stallCnt;
  wire         rdTaken = hsel && hready && htrans[1] && !hwrite;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // cycles since a trigger write and length of the current stall
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctlWr     <= 1'b0;
      sinceTrig <= 4'hF;
      stallCnt  <= 32'h0;
    end else begin
      ctlWr <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h10;
      if (ctlWr && hready && hwdata[1])
        sinceTrig <= 4'h0;
      else if (sinceTrig != 4'hF)
        sinceTrig <= sinceTrig + 4'h1; // saturates so old writes stay old
      stallCnt <= cpuStall ? stallCnt + 32'h1 : 32'h0;
    end
  end

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not ready or not okay");
  property p_key_zero;
    rdTaken && haddr[7:0] == 8'h14 |=> hrdata == 32'h0;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key register read not zero");
  property p_data_width;
    rdTaken && haddr[7:0] == 8'h0C |=> hrdata[31:6] == 26'h0;
  endproperty
  a_data_width: assert property (p_data_width)
    else $error("data high wider than six bits");
  property p_addr_width;
    rdTaken && haddr[7:0] == 8'h04 |=> hrdata[31:7] == 25'h0;
  endproperty
  a_addr_width: assert property (p_addr_width)
    else $error("address high wider than seven bits");
  property p_read_hold;
    $changed(hrdata) |-> $past(rdTaken);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read data changed without a read");
  property p_stall_max;
    stallCnt <= OP_CYCLES + 16;
  endproperty
  a_stall_max: assert property (p_stall_max)
    else $error("stall lasted too long");
  property p_stall_min;
    $fell(cpuStall) |-> stallCnt >= OP_CYCLES - 1;
  endproperty
  a_stall_min: assert property (p_stall_min)
    else $error("stall ended before the timer ran out");
  property p_stall_cause;
    $rose(cpuStall) |-> sinceTrig <= 4'h4;
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without a trigger write");
  property p_guard_all;
    $rose(cpuStall) |-> $past(selfProgramGuard, 4) != 2'h0;
  endproperty
  a_guard_all: assert property (p_guard_all)
    else $error("operation started with whole array guarded");
endmodule // pfsw_flash_ctrl_assertions

bind pfsw_flash_ctrl pfsw_flash_ctrl_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .selfProgramGuard(selfProgramGuard),
  .cpuStall(cpuStall));
`default_nettype wire

//--- tb.sv
// self-checking bench for the flash self-write controller
// assumes: the timer parameter is shortened to 64 cycles for simulation
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int          OPS  = 64;
  localparam logic [14:0] ROWA = 15'h6020;
  localparam logic [14:0] ROWB = 15'h6040;
  logic        clock, rstn, porRstn, hsel, hwrite, codeProtect;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans, selfProgramGuard;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, cpuStall;
  int          errors, check_count;

  pfsw_flash_ctrl #(.OP_CYCLES(OPS)) u_dut (
    .clock(clock), .rstn(rstn), .porRstn(porRstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .selfProgramGuard(selfProgramGuard),
    .codeProtect(codeProtect), .cpuStall(cpuStall));

  // free-running 100 MHz clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready; a hang ends the run
  task wait_ready;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        report_and_stop;
      end
      @(posedge clock);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x & m, e);
  endtask

  // poll a control bit until hardware clears it
  task poll(input int b);
    int n;
    logic [31:0] x;
    n = 0;
    bus(1'b0, 8'h10, 32'h0, x);
    while (x[b] !== 1'b0) begin
      n++;
      if (n > 100) begin
        errors++;
        report_and_stop;
      end
      bus(1'b0, 8'h10, 32'h0, x);
    end
  endtask

  task set_addr(input logic [14:0] a);
    wr(8'h00, {24'h0, a[7:0]});
    wr(8'h04, {25'h0, a[14:8]});
  endtask

  task read_word(input logic [14:0] a, input logic [13:0] e);
    set_addr(a);
    wr(8'h10, 32'h01);
    poll(0);
    rdc(8'h08, 32'hFFFFFFFF, {24'h0, e[7:0]});
    rdc(8'h0C, 32'hFFFFFFFF, {26'h0, e[13:8]});
  endtask

  // mode first, key, trigger; kind 0 refused, 1 short, 2 stalls
  task go(input logic [7:0] mode, input int kind);
    wr(8'h10, {24'h0, mode});
    wr(8'h14, 32'h55);
    wr(8'h14, 32'hAA);
    wr(8'h10, {24'h0, mode | 8'h02});
    if (kind == 2) begin
      wr(8'h10, {24'h0, mode}); // a zero must not end the operation
      rdc(8'h10, 32'h2, 32'h2);
      @(negedge clock);
      check({31'h0, cpuStall}, 32'h1);
      @(posedge clock);
    end
    if (kind == 0)
      rdc(8'h10, 32'h2, 32'h0);
    poll(1);
  endtask

  // main sequence
  initial begin
    logic [13:0] d;
    errors = 0;
    check_count = 0;
    {rstn, porRstn, hsel, hwrite, codeProtect} = 5'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    selfProgramGuard = 2'h3;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    @(posedge clock);
    rdc(8'h10, 32'hFFFFFFFF, 32'h0);
    wr(8'h14, 32'h55);
    rdc(8'h14, 32'hFFFFFFFF, 32'h0);
    wr(8'h20, 32'hFF);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
    $display("test reset_and_reads done");
    set_addr(15'h0020);
    wr(8'h10, 32'h14);
    wr(8'h10, 32'h16);
    rdc(8'h10, 32'h2, 32'h0);
    go(8'h10, 0);
    wr(8'h10, 32'h14); // enable first, so only the key order refuses
    wr(8'h14, 32'hAA);
    wr(8'h14, 32'h55);
    wr(8'h10, 32'h16);
    rdc(8'h10, 32'h2, 32'h0);
    for (int g = 0; g < 3; g++) begin
      selfProgramGuard <= 2'(g);
      repeat (6) @(posedge clock);
      go(8'h14, 0);
    end
    selfProgramGuard <= 2'h2;
    codeProtect <= 1'b1;
    repeat (6) @(posedge clock);
    rdc(8'h10, 32'h40, 32'h40);
    $display("test refusals done");
    for (int i = 0; i < 2; i++) begin
      set_addr(i ? ROWB : ROWA);
      go(8'h14, 2);
    end
    read_word(ROWA, 14'h3FFF);
    read_word(ROWA + 15'd31, 14'h3FFF);
    $display("test erase done");
    for (int i = 0; i < 2; i++) begin
      d = i ? 14'h2B3D : 14'h1A5C;
      set_addr(ROWA + (i ? 15'd31 : 15'd0));
      wr(8'h08, {24'h0, d[7:0]});
      wr(8'h0C, {26'h0, d[13:8]});
      go(8'h24, 1);
    end
    set_addr(ROWA);
    go(8'h04, 2);
    read_word(ROWA, 14'h1A5C);
    read_word(ROWA + 15'd31, 14'h2B3D);
    read_word(ROWA + 15'd5, 14'h3FFF);
    set_addr(ROWB);
    go(8'h04, 2);
    read_word(ROWB, 14'h3FFF);
    $display("test program done");
    wr(8'h10, 32'h14);
    wr(8'h14, 32'h55);
    wr(8'h14, 32'hAA);
    wr(8'h10, 32'h16);
    repeat (10) @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    check({31'h0, cpuStall}, 32'h0);
    @(posedge clock);
    rdc(8'h10, 32'h8, 32'h8);
    $display("test abort done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
